// File: logic/dif_pkg.sv
// Constants shared by the converter input FIFO block.
// Assumes a single 200 MHz bus clock and word-aligned AHB-Lite access.
package dif_pkg;

    // ************************************************************
    // Geometry
    // ************************************************************
    localparam int          DIF_SLOTS       = 8;
    localparam int          DIF_PTR_W       = 3;
    localparam int          DIF_DATA_W      = 16;
    localparam int          DIF_CLK_PERIOD_NS = 5;

    // ************************************************************
    // Register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [7:0]  IDX_PARITY_CTRL = 8'h6a;
    localparam logic [7:0]  IDX_PAR_RISE    = 8'h6b;
    localparam logic [7:0]  IDX_PAR_FALL    = 8'h6c;
    localparam logic [7:0]  IDX_FIFO_CTRL   = 8'h70;
    localparam logic [7:0]  IDX_FIFO_STAT   = 8'h71;
    localparam logic [7:0]  IDX_IRQ_STAT    = 8'h72;
    localparam logic [7:0]  IDX_IRQ_MASK    = 8'h73;
    localparam logic [7:0]  IDX_VERSION     = 8'h7f;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int          PC_ENABLE_BIT   = 7;
    localparam int          PC_EVEN_BIT     = 6;
    localparam int          PC_CLEAR_BIT    = 5;
    localparam int          PC_FALL_FLAG_BIT = 1;
    localparam int          PC_RISE_FLAG_BIT = 0;
    localparam int          FC_DEPTH_LSB    = 0;
    localparam int          FC_INTERP_BIT   = 3;
    localparam int          FC_SOFT_RST_BIT = 4;
    localparam int          FS_WR_LSB       = 0;
    localparam int          FS_RD_LSB       = 4;
    localparam int          FS_SEP_LSB      = 8;
    localparam int          IRQ_RISE_BIT    = 0;
    localparam int          IRQ_FALL_BIT    = 1;
    localparam int          IRQ_FRAME_BIT   = 2;
    localparam int          IRQ_SYNC_BIT    = 3;
    localparam int          IRQ_W           = 4;

    // ************************************************************
    // Values after reset and limits
    // ************************************************************
    localparam logic [7:0]  PAR_CNT_RST     = 8'h00;
    localparam logic [7:0]  PAR_CNT_MAX     = 8'hff;
    localparam logic [2:0]  DEPTH_RST       = 3'h4;
    localparam logic        INTERP_RST      = 1'b1;
    localparam logic [3:0]  IRQ_MASK_RST    = 4'h0;

endpackage : dif_pkg

// File: logic/dif_slot_ram.sv
// Eight-slot sample store of the input FIFO.
// Assumes one clock; read data appear one cycle after the read enable.
`timescale 1ns/10ps
module dif_slot_ram #(
    parameter int DW    = 16,
    parameter int AW    = 3
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic          re,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata_r
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    // ************************************************************
    // Storage
    // ************************************************************
    // No reset on the array; slots are defined once written
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (re) begin
            rdata_r <= mem[raddr];
        end
    end

endmodule : dif_slot_ram

// File: logic/dif_fifo_top.sv
// Converter input FIFO with latency preset, split resets and parity count.
// Assumes pins are asynchronous to hclk; the bus clock stands in for the
// converter sample clock, hclk runs well above the source data clock.
//
// Contract
// - Count falling-edge parity errors in eight bits, saturating, never wrapping.
// - Falling error count readable at its own offset, read-only, zero after reset.
// - Read-only version register returns a fixed identifier; writes ignored.
// - Eight slots; write and read pointers step in order and wrap.
// - Depth is slots from read to write pointer, equal to latency.
// - FIFO reset sets pointer separation to a preset nonzero depth, four; here the preset is the depth field, four after reset, writable 0 to 7.
// - In two-times interpolation the half-rate clock reads FIFO and feeds filter.
// - Divider phase is forced to a known state, avoiding latency ambiguity.
// - Write side resets from frame reference, read side from sync reference.
// - Writing one to parity clear zeroes both parity error counters.
// - Falling parity flag reads one once any falling error was seen.
`timescale 1ns/10ps
module dif_fifo_top
    import dif_pkg::*;
#(
    parameter int         DW         = DIF_DATA_W,
    parameter logic [7:0] VERSION_ID = 8'h5a    // Arbitrary value
) (
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic      [31:0]   hrdata,
    output logic               hresp,
    input  wire logic          source_data_clock,
    input  wire logic [DW-1:0] data_pins,
    input  wire logic          parity_pin,
    input  wire logic          frame_ref,
    input  wire logic          sync_ref,
    output logic      [DW-1:0] sample_out,
    output logic               sample_strobe,
    output logic               irq
);

    localparam int SW = DW + 4;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [SW-1:0]        pin_meta_r;
    logic [SW-1:0]        pin_sync_r;
    logic [2:0]           edge_prev_r;
    logic                 dclk_s;
    logic                 frame_s;
    logic                 sync_s;
    logic [DW-1:0]        data_s;
    logic                 par_s;
    logic                 dclk_rise;
    logic                 dclk_fall;
    logic                 frame_rise;
    logic                 sync_rise;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end else begin
            pin_meta_r <= {sync_ref, frame_ref, source_data_clock,
                           parity_pin, data_pins};
            pin_sync_r <= pin_meta_r;
        end
    end

    assign data_s = pin_sync_r[DW-1:0];
    assign par_s  = pin_sync_r[DW];
    assign dclk_s = pin_sync_r[DW+1];
    assign frame_s = pin_sync_r[DW+2];
    assign sync_s = pin_sync_r[DW+3];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            edge_prev_r <= 3'h0;
        end else begin
            edge_prev_r <= {sync_s, frame_s, dclk_s};
        end
    end

    // Rising edge carries slots 0, 2, 4 and 6, falling edge slots 1, 3, 5 and 7
    assign dclk_rise  = dclk_s & ~edge_prev_r[0];
    assign dclk_fall  = ~dclk_s & edge_prev_r[0];
    assign frame_rise = frame_s & ~edge_prev_r[1];
    assign sync_rise  = sync_s & ~edge_prev_r[2];

    // ************************************************************
    // Control registers
    // ************************************************************
    logic                 par_en_r;
    logic                 par_even_r;
    logic [2:0]           depth_r;
    logic                 interp2_r;
    logic [IRQ_W-1:0]     irq_mask_r;
    logic                 wr_pend_r;
    logic [7:0]           wr_idx_r;
    logic                 bus_we;
    logic                 par_clear;
    logic                 soft_rst;

    assign bus_we    = wr_pend_r;
    assign par_clear = bus_we && wr_idx_r == IDX_PARITY_CTRL
                       && hwdata[PC_CLEAR_BIT];
    assign soft_rst  = bus_we && wr_idx_r == IDX_FIFO_CTRL
                       && hwdata[FC_SOFT_RST_BIT];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            par_en_r   <= 1'b0;
            par_even_r <= 1'b0;
            depth_r    <= DEPTH_RST;
            interp2_r  <= INTERP_RST;
            irq_mask_r <= IRQ_MASK_RST;
        end else if (bus_we) begin
            case (wr_idx_r)
                IDX_PARITY_CTRL: begin
                    par_en_r   <= hwdata[PC_ENABLE_BIT];
                    par_even_r <= hwdata[PC_EVEN_BIT];
                end
                IDX_FIFO_CTRL: begin
                    depth_r   <= hwdata[FC_DEPTH_LSB +: 3];
                    interp2_r <= hwdata[FC_INTERP_BIT];
                end
                IDX_IRQ_MASK: begin
                    irq_mask_r <= hwdata[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // Parity check and error counters
    // ************************************************************
    logic                 par_bad;
    logic                 rise_err;
    logic                 fall_err;
    logic [7:0]           rise_cnt_r;
    logic [7:0]           fall_cnt_r;
    logic                 rise_flag_r;
    logic                 fall_flag_r;

    // Even mode expects an even count of ones over data and parity
    assign par_bad  = par_en_r && ((^{par_s, data_s}) == par_even_r);
    assign rise_err = dclk_rise & par_bad;
    assign fall_err = dclk_fall & par_bad;

    // Clear beats a coincident count; the flags below let the set win
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rise_cnt_r <= PAR_CNT_RST;
            fall_cnt_r <= PAR_CNT_RST;
        end else if (par_clear) begin
            rise_cnt_r <= PAR_CNT_RST;
            fall_cnt_r <= PAR_CNT_RST;
        end else begin
            if (rise_err && rise_cnt_r != PAR_CNT_MAX) begin
                rise_cnt_r <= rise_cnt_r + 8'h01;
            end
            if (fall_err && fall_cnt_r != PAR_CNT_MAX) begin
                fall_cnt_r <= fall_cnt_r + 8'h01;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rise_flag_r <= 1'b0;
            fall_flag_r <= 1'b0;
        end else begin
            if (rise_err) begin
                rise_flag_r <= 1'b1;
            end else if (par_clear) begin
                rise_flag_r <= 1'b0;
            end
            if (fall_err) begin
                fall_flag_r <= 1'b1;
            end else if (par_clear) begin
                fall_flag_r <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Pointers and divided read clock
    // ************************************************************
    logic [DIF_PTR_W-1:0] wr_ptr_r;
    logic [DIF_PTR_W-1:0] rd_ptr_r;
    logic [DIF_PTR_W-1:0] sep;
    logic                 div_r;
    logic                 wr_step;
    logic                 rd_step;

    // equal depth aligns outputs only if sources stay aligned
    assign wr_step = dclk_rise | dclk_fall;
    assign rd_step = ~sync_rise & (interp2_r ? div_r : 1'b1);
    assign sep     = wr_ptr_r - rd_ptr_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_r <= 1'b0;
        end else if (sync_rise) begin
            div_r <= 1'b0;
        end else begin
            div_r <= ~div_r;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr_r <= '0;
        end else if (frame_rise) begin
            wr_ptr_r <= '0;
        end else if (wr_step) begin
            wr_ptr_r <= wr_ptr_r + 3'h1;
        end
    end

    // Read side trails slot 0 by the preset, so split resets line up
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ptr_r <= 3'h0 - DEPTH_RST;
        end else if (sync_rise) begin
            rd_ptr_r <= 3'h0 - depth_r;
        end else if (soft_rst) begin
            rd_ptr_r <= wr_ptr_r - depth_r;
        end else if (rd_step) begin
            rd_ptr_r <= rd_ptr_r + 3'h1;
        end
    end

    dif_slot_ram #(
        .DW (DW),
        .AW (DIF_PTR_W)
    ) u_ram (
        .clk     (hclk),
        .we      (wr_step),
        .waddr   (wr_ptr_r),
        .wdata   (data_s),
        .re      (rd_step),
        .raddr   (rd_ptr_r),
        .rdata_r (sample_out)
    );

    // Strobe marks each read step: the divided clock edge in two-times interpolation, every cycle except a sync edge at full rate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sample_strobe <= 1'b0;
        end else begin
            sample_strobe <= rd_step;
        end
    end

    // ************************************************************
    // Interrupt status
    // ************************************************************
    logic [IRQ_W-1:0]     irq_stat_r;
    logic [IRQ_W-1:0]     irq_set;
    logic [IRQ_W-1:0]     irq_clr;

    assign irq_set = {sync_rise, frame_rise, fall_err, rise_err};
    assign irq_clr = (bus_we && wr_idx_r == IDX_IRQ_STAT) ?
                     hwdata[IRQ_W-1:0] : '0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_r <= '0;
            irq        <= 1'b0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
            irq        <= |(irq_stat_r & irq_mask_r);
        end
    end

    // ************************************************************
    // AHB-Lite slave, zero wait states
    // ************************************************************
    logic                 addr_ok;
    logic [7:0]           a_idx;
    logic [31:0]          rd_val;

    assign addr_ok = hsel & hready & htrans[1];
    assign a_idx   = haddr[9:2];

    always_comb begin
        rd_val = 32'h0;
        case (a_idx)
            IDX_PARITY_CTRL: begin
                rd_val[PC_ENABLE_BIT]    = par_en_r;
                rd_val[PC_EVEN_BIT]      = par_even_r;
                rd_val[PC_FALL_FLAG_BIT] = fall_flag_r;
                rd_val[PC_RISE_FLAG_BIT] = rise_flag_r;
            end
            IDX_PAR_RISE:  rd_val[7:0] = rise_cnt_r;
            IDX_PAR_FALL:  rd_val[7:0] = fall_cnt_r;
            IDX_FIFO_CTRL: begin
                rd_val[FC_DEPTH_LSB +: 3] = depth_r;
                rd_val[FC_INTERP_BIT]     = interp2_r;
            end
            IDX_FIFO_STAT: begin
                rd_val[FS_WR_LSB +: 3]  = wr_ptr_r;
                rd_val[FS_RD_LSB +: 3]  = rd_ptr_r;
                rd_val[FS_SEP_LSB +: 3] = sep;
            end
            IDX_IRQ_STAT:  rd_val[IRQ_W-1:0] = irq_stat_r;
            IDX_IRQ_MASK:  rd_val[IRQ_W-1:0] = irq_mask_r;
            IDX_VERSION:   rd_val[7:0] = VERSION_ID;
            default:       rd_val = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= 8'h00;
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend_r <= addr_ok & hwrite;
            if (addr_ok) begin
                wr_idx_r <= a_idx;
            end
            if (addr_ok && !hwrite) begin
                hrdata <= rd_val;
            end
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_read_version;
        addr_ok && !hwrite && a_idx == IDX_VERSION;
    endsequence

    property p_fall_sat;
        @(posedge hclk) disable iff (!hresetn)
        (fall_cnt_r == PAR_CNT_MAX && !par_clear) |=>
            fall_cnt_r == PAR_CNT_MAX;
    endproperty
    a_fall_sat: assert property (p_fall_sat)
        else $error("falling error count left saturation");

    property p_fall_inc;
        @(posedge hclk) disable iff (!hresetn)
        (fall_err && !par_clear && fall_cnt_r != PAR_CNT_MAX) |=>
            fall_cnt_r == $past(fall_cnt_r) + 8'h01;
    endproperty
    a_fall_inc: assert property (p_fall_inc)
        else $error("falling error not counted");

    property p_version;
        @(posedge hclk) disable iff (!hresetn)
        s_read_version |=> hrdata == {24'h0, VERSION_ID};
    endproperty
    a_version: assert property (p_version)
        else $error("version read wrong");

    property p_clear;
        @(posedge hclk) disable iff (!hresetn)
        par_clear |=> rise_cnt_r == 8'h00 && fall_cnt_r == 8'h00;
    endproperty
    a_clear: assert property (p_clear)
        else $error("parity counters not cleared");

    property p_flag;
        @(posedge hclk) disable iff (!hresetn)
        fall_err |=> fall_flag_r ##1 (fall_flag_r || $past(par_clear));
    endproperty
    a_flag: assert property (p_flag)
        else $error("falling flag not set");

    property p_wr_wrap;
        @(posedge hclk) disable iff (!hresetn)
        (wr_ptr_r == 3'h7 && wr_step && !frame_rise) |=> wr_ptr_r == 3'h0;
    endproperty
    a_wr_wrap: assert property (p_wr_wrap)
        else $error("write pointer did not wrap");

    property p_depth;
        @(posedge hclk) disable iff (!hresetn)
        (soft_rst && !sync_rise && !wr_step && !frame_rise) |=>
            sep == $past(depth_r);
    endproperty
    a_depth: assert property (p_depth)
        else $error("separation not preset");

    // Two undisturbed hclk cycles after a read
    sequence s_half_rate;
        (interp2_r && rd_step) ##1 (interp2_r && !sync_rise) [*2];
    endsequence

    property p_half_rate;
        @(posedge hclk) disable iff (!hresetn)
        s_half_rate |-> rd_step && !$past(rd_step);
    endproperty
    a_half_rate: assert property (p_half_rate)
        else $error("read rate not half");

    property p_phase;
        @(posedge hclk) disable iff (!hresetn)
        sync_rise |-> !rd_step ##1 (div_r == 1'b0);
    endproperty
    a_phase: assert property (p_phase)
        else $error("divider phase not forced");

    property p_frame;
        @(posedge hclk) disable iff (!hresetn)
        frame_rise |=> wr_ptr_r == 3'h0;
    endproperty
    a_frame: assert property (p_frame)
        else $error("write side not reset");

    property p_strobe;
        @(posedge hclk) disable iff (!hresetn)
        rd_step |=> sample_strobe && rd_ptr_r == $past(rd_ptr_r) + 3'h1
                    || $past(soft_rst);
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("read step lost");

endmodule : dif_fifo_top

// File: dv/dif_source_model.sv
// Behavioural sample source on the far side of the pin interface.
// Assumes hclk only paces it; the data clock stands still between frames.
`timescale 1ns/10ps
module dif_source_model (
    input  wire logic        hclk,
    input  wire logic        req,
    input  wire logic [9:0]  n_edges,
    input  wire logic        bad_fall,
    output logic             source_data_clock,
    output logic      [15:0] data_pins,
    output logic             parity_pin,
    output logic             done
);
    logic [15:0] word;

    initial begin
        source_data_clock = 1'b0;
        data_pins = 16'h0000;
        parity_pin = 1'b0;
        done = 1'b0;
        word = 16'h1234;
        forever begin
            @(posedge hclk);
            if (req && !done) begin
                for (int i = 0; i < n_edges; i++) begin
                    word = word + 16'h0101;
                    // Data settle three cycles either side of the edge
                    data_pins <= word;
                    // Clock high now means the next edge is a falling one
                    parity_pin <= (bad_fall && source_data_clock) ?
                                  ~^word : ^word;
                    repeat (3) @(posedge hclk);
                    source_data_clock <= ~source_data_clock;
                    repeat (3) @(posedge hclk);
                end
                done <= 1'b1;
            end else if (!req) begin
                done <= 1'b0;
            end
        end
    end
endmodule : dif_source_model

// File: dv/dif_fifo_top_test.sv
// Self-checking bench for the converter input FIFO block.
// Assumes the bench is the only AHB-Lite master and the model the source.
`timescale 1ns/10ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin \
    n_errors++; $display("unexpected %s expected %0h seen %0h", n, e, a); \
    end end
module dif_fifo_top_test;
    import dif_pkg::*;
    localparam logic [7:0] VID = 8'h3c;  // Arbitrary value
    typedef struct {logic [7:0] idx; logic [31:0] exp;} dif_row_type;

    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        sdc, par, frame_ref, sync_ref, strobe, req, bad, done;
    logic [15:0] pins, sample_out;
    logic [9:0]  n_edges;
    int          n_errors, total_checks, c, d1, d2, h;
    logic [2:0]  w0;
    dif_row_type rows[6] = '{'{IDX_PAR_FALL, 32'h0},
        '{IDX_VERSION, {24'h0, VID}}, '{IDX_PARITY_CTRL, 32'h0},
        '{IDX_FIFO_CTRL, 32'h0c}, '{IDX_IRQ_MASK, 32'h0}, '{8'h10, 32'h0}};

    assign hready = hreadyout;

    dif_fifo_top #(.VERSION_ID(VID)) dif_fifo_top_inst (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .source_data_clock(sdc), .data_pins(pins), .parity_pin(par),
        .frame_ref(frame_ref), .sync_ref(sync_ref), .sample_out(sample_out),
        .sample_strobe(strobe), .irq(irq));

    dif_source_model dif_source_model_inst (.hclk(hclk), .req(req),
        .n_edges(n_edges), .bad_fall(bad), .source_data_clock(sdc),
        .data_pins(pins), .parity_pin(par), .done(done));

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    task automatic tmo;
        n_errors++;
        $display("unexpected wait expected 1 seen 0");
        close_out();
    endtask : tmo

    // ************************************************************
    // Bus and stimulus tasks
    // ************************************************************
    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [31:0] wd);
        int k;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, idx, 2'h0};
        k = 0;
        do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 99);
        if (k >= 99) tmo();
        rd = hrdata;
    endtask : bus

    task automatic send(input int n, input logic b);
        int k;
        @(posedge hclk);
        n_edges <= n[9:0];
        bad <= b;
        req <= 1'b1;
        k = 0;
        do begin @(posedge hclk); k++; end while (done !== 1'b1 && k < 9000);
        if (k >= 9000) tmo();
        req <= 1'b0;
        repeat (8) @(posedge hclk);
    endtask : send

    // Counts reads and reads that return the last word the source sent
    task automatic strobes(output int n, output int hit);
        n = 0;
        hit = 0;
        repeat (40) begin
            @(posedge hclk);
            #1 if (strobe === 1'b1) begin
                n++;
                if (sample_out === dif_source_model_inst.word) hit++;
            end
        end
    endtask : strobes

    task automatic sync_delay(output int d);
        @(posedge hclk);
        sync_ref <= 1'b1;
        d = 0;
        // Skip strobes already in flight before the edge is seen
        do begin @(posedge hclk); #1 d++; end
        while ((d < 6 || strobe !== 1'b1) && d < 30);
        sync_ref <= 1'b0;
        repeat (5) @(posedge hclk);
    endtask : sync_delay

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        {frame_ref, sync_ref, req, bad, n_edges, n_errors, total_checks} = '0;
        hsize = 3'h2;
        hresetn = 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (rows[i]) begin
            bus(1'b0, rows[i].idx, 32'h0);
            `CHK("reg", rows[i].exp, rd)
        end
        bus(1'b1, IDX_VERSION, 32'hff);
        bus(1'b0, IDX_VERSION, 32'h0);
        `CHK("version", {24'h0, VID}, rd)
        bus(1'b1, IDX_PARITY_CTRL, 32'hc0);
        send(2, 1'b1);
        bus(1'b1, IDX_PAR_FALL, 32'h55);
        bus(1'b0, IDX_PAR_FALL, 32'h0);
        `CHK("fall count", 32'h1, rd)
        bus(1'b0, IDX_PARITY_CTRL, 32'h0);
        `CHK("flags", 32'hc2, rd)
        `CHK("irq off", 1'b0, irq)
        bus(1'b1, IDX_IRQ_MASK, 32'h2);
        repeat (2) @(posedge hclk);
        `CHK("irq on", 1'b1, irq)
        bus(1'b1, IDX_IRQ_STAT, 32'h2);
        repeat (2) @(posedge hclk);
        `CHK("irq clear", 1'b0, irq)
        send(600, 1'b1);
        bus(1'b0, IDX_PAR_FALL, 32'h0);
        `CHK("fall sat", 32'hff, rd)
        bus(1'b0, IDX_PAR_RISE, 32'h0);
        `CHK("rise count", 32'h0, rd)
        bus(1'b1, IDX_PARITY_CTRL, 32'he0);
        bus(1'b0, IDX_PAR_FALL, 32'h0);
        `CHK("fall clear", 32'h0, rd)
        bus(1'b0, IDX_FIFO_STAT, 32'h0);
        w0 = rd[2:0];
        send(10, 1'b0);
        bus(1'b0, IDX_FIFO_STAT, 32'h0);
        `CHK("wr ptr", w0 + 3'd2, rd[2:0])
        frame_ref <= 1'b1;
        repeat (8) @(posedge hclk);
        frame_ref <= 1'b0;
        bus(1'b0, IDX_FIFO_STAT, 32'h0);
        `CHK("wr ptr frame", 3'h0, rd[2:0])
        strobes(c, h);
        `CHK("strobes half", 20, c)
        `CHK("sample half", 1'b1, h >= 2)
        bus(1'b1, IDX_FIFO_CTRL, 32'h1a);
        bus(1'b0, IDX_FIFO_CTRL, 32'h0);
        `CHK("depth", 32'h0a, rd)
        bus(1'b1, IDX_FIFO_CTRL, 32'h04);
        strobes(c, h);
        `CHK("strobes full", 40, c)
        `CHK("sample full", 5, h)
        bus(1'b1, IDX_FIFO_CTRL, 32'h0c);
        // Odd gap between the two edges puts a free divider in the other phase
        sync_delay(d1);
        sync_delay(d2);
        `CHK("sync phase", d1, d2)
        send(4, 1'b1);
        bus(1'b0, IDX_PAR_FALL, 32'h0);
        `CHK("fall before reset", 32'h2, rd)
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, IDX_PAR_FALL, 32'h0);
        `CHK("fall reset", 32'h0, rd)
        close_out();
    end
endmodule : dif_fifo_top_test
